// ---- misp_map.svh ----
// Purpose: offsets, reset values and bit positions of the maskable irq block
// Assumes: register index times four gives the byte address on apb
// Notes: definitions only
`ifndef MISP_MAP_SVH
`define MISP_MAP_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define MISP_IDX_VECTOR 6'h00
`define MISP_IDX_STAT_LO 6'h0A
`define MISP_IDX_STAT_HI 6'h0C
`define MISP_IDX_EN_LO 6'h0E
`define MISP_IDX_EN_HI 6'h10
`define MISP_IDX_EVT 6'h14
`define MISP_IDX_EVT_MASK 6'h16

// ----------------------------------------
// values and fields
// ----------------------------------------
`define MISP_EN_RST 16'hFFFF
`define MISP_VEC_BASE 8'h10
`define MISP_SRC_NONE0 0
`define MISP_SRC_NONE24 24
`define MISP_SRC_USED 32'hFEFFFFFE
`define MISP_EVT_SPUR 0
`define MISP_EVT_ACK 1
`define MISP_EVT_W 2

`endif

// ---- misp_pkg.sv ----
// Purpose: types of the maskable irq block
// Assumes: nothing
// Notes: constants live in misp_map.svh
package misp_pkg;

	typedef enum logic [0:0] {
		MISP_IDLE = 1'b0,
		MISP_ANSWER = 1'b1
	} misp_bus_e;

	typedef struct packed {
		logic valid;
		logic [4:0] idx;
	} misp_pick_s;

endpackage

// ---- misp_core.sv ----
// Purpose: maskable irq status, enables, priority vector and nesting gate
// Assumes: apb slave, one clock, request inputs synchronous to mclk_i
// Notes: every output comes from a flip-flop
`timescale 1ns/1ps
`include "misp_map.svh"

module misp_core
	import misp_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [31:0] irq_src_i,
	input wire logic nmi_i,
	input wire logic gie_i,
	input wire logic inta_i,
	output logic cpu_irq_o,
	output logic nmi_o,
	output logic [7:0] vector_o,
	output logic irq_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
		logic [ADDR_W-1:0] b;
		b = ADDR_W'({idx, 2'b00});
		hit = (a == b);
	endfunction

	// highest set bit wins because later iterations overwrite
	function automatic misp_pick_s pick(input logic [31:0] v);
		misp_pick_s p;
		p.valid = 1'b0;
		p.idx = 5'h00;
		for (int i = 0; i < 32; i++)
		begin
			if (v[i])
			begin
				p.valid = 1'b1;
				p.idx = 5'(i);
			end
		end
		pick = p;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] req_q;
	logic [15:0] en_lo_q;
	logic [15:0] en_hi_q;
	logic [`MISP_EVT_W-1:0] evt_q;
	logic [`MISP_EVT_W-1:0] evt_mask_q;
	logic block_q;
	misp_bus_e bus_q;
	logic [31:0] pend;
	misp_pick_s win;
	logic setup;
	logic done;
	logic wr_done;
	logic mapped;
	logic [31:0] rd_d;
	logic [`MISP_EVT_W-1:0] evt_set;

	assign setup = psel_i && penable_i && (bus_q == MISP_IDLE);
	assign done = psel_i && penable_i && pready_o;
	assign wr_done = done && pwrite_i;

	// ----------------------------------------
	// request sampling
	// ----------------------------------------
	// level follow, no latching: a dropped request vanishes from status
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			req_q <= 32'h00000000;
		else
			req_q <= irq_src_i & `MISP_SRC_USED;
	end

	// ----------------------------------------
	// priority and vector
	// ----------------------------------------
	assign pend = req_q & {en_hi_q, en_lo_q} & `MISP_SRC_USED;
	assign win = pick(pend);

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			vector_o <= `MISP_VEC_BASE;
		else
			vector_o <= `MISP_VEC_BASE + {3'b000, win.idx};
	end

	// ----------------------------------------
	// nesting gate
	// ----------------------------------------
	// one flag, not a depth counter, so nesting depth is unbounded
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			block_q <= 1'b0;
		else if (inta_i)
			block_q <= 1'b1;
		else if (!gie_i)
			block_q <= 1'b0;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cpu_irq_o <= 1'b0;
		else
			cpu_irq_o <= win.valid && gie_i && !block_q && !inta_i;
	end

	// non-maskable path ignores the nesting gate entirely
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			nmi_o <= 1'b0;
		else
			nmi_o <= nmi_i;
	end

	// ----------------------------------------
	// enable registers
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_lo_q <= `MISP_EN_RST;
			en_hi_q <= `MISP_EN_RST;
		end
		else if (wr_done && hit(paddr_i, `MISP_IDX_EN_LO))
			en_lo_q <= pwdata_i[15:0];
		else if (wr_done && hit(paddr_i, `MISP_IDX_EN_HI))
			en_hi_q <= pwdata_i[15:0];
	end

	// ----------------------------------------
	// event status and interrupt
	// ----------------------------------------
	// ack with nothing pending gives the base vector, a spurious entry
	always_comb
	begin
		evt_set = '0;
		evt_set[`MISP_EVT_SPUR] = inta_i && (vector_o == `MISP_VEC_BASE);
		evt_set[`MISP_EVT_ACK] = inta_i;
	end

	// set beats a write-one clear in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			evt_q <= '0;
		else if (wr_done && hit(paddr_i, `MISP_IDX_EVT))
			evt_q <= (evt_q & ~pwdata_i[`MISP_EVT_W-1:0]) | evt_set;
		else
			evt_q <= evt_q | evt_set;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			evt_mask_q <= '0;
		else if (wr_done && hit(paddr_i, `MISP_IDX_EVT_MASK))
			evt_mask_q <= pwdata_i[`MISP_EVT_W-1:0];
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(evt_q & evt_mask_q);
	end

	// ----------------------------------------
	// apb read mux
	// ----------------------------------------
	always_comb
	begin
		rd_d = 32'h00000000;
		mapped = 1'b1;
		if (hit(paddr_i, `MISP_IDX_VECTOR))
			rd_d = {24'h000000, vector_o};
		else if (hit(paddr_i, `MISP_IDX_STAT_LO))
			rd_d = {16'h0000, req_q[15:1], 1'b0};
		else if (hit(paddr_i, `MISP_IDX_STAT_HI))
			rd_d = {16'h0000, req_q[31:16]};
		else if (hit(paddr_i, `MISP_IDX_EN_LO))
			rd_d = {16'h0000, en_lo_q};
		else if (hit(paddr_i, `MISP_IDX_EN_HI))
			rd_d = {16'h0000, en_hi_q};
		else if (hit(paddr_i, `MISP_IDX_EVT))
			rd_d = {30'h00000000, evt_q};
		else if (hit(paddr_i, `MISP_IDX_EVT_MASK))
			rd_d = {30'h00000000, evt_mask_q};
		else
			mapped = 1'b0;
	end

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	// one wait state keeps prdata and pready straight from flops
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			bus_q <= MISP_IDLE;
		else
		begin
			case (bus_q)
				MISP_IDLE:
					if (setup)
						bus_q <= MISP_ANSWER;
				MISP_ANSWER:
					bus_q <= MISP_IDLE;
				default:
					bus_q <= MISP_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end
		else if (setup)
		begin
			pready_o <= 1'b1;
			pslverr_o <= !mapped;
			prdata_o <= pwrite_i ? 32'h00000000 : rd_d;
		end
		else
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_ack;
		inta_i;
	endsequence

	sequence s_gie_held;
		gie_i [*3];
	endsequence

	// core drops the global enable, then raises it again
	sequence s_gie_back;
		!gie_i && !inta_i ##1 gie_i && !inta_i;
	endsequence

	follow_status_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		1 |=> req_q == ($past(irq_src_i) & `MISP_SRC_USED))
		else $error("status does not follow request inputs");

	read_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		done && !pwrite_i && hit(paddr_i, `MISP_IDX_STAT_LO)
		|-> prdata_o[15:1] == $past(req_q[15:1]))
		else $error("low status read wrong");

	bit_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		done && !pwrite_i && hit(paddr_i, `MISP_IDX_STAT_LO) |-> !prdata_o[0])
		else $error("low status bit 0 not zero");

	read_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		done && !pwrite_i && hit(paddr_i, `MISP_IDX_STAT_HI)
		|-> prdata_o[15:0] == $past(req_q[31:16]) && prdata_o[31:16] == 16'h0000)
		else $error("high status read wrong");

	top_wins_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		req_q[31] && en_hi_q[15] |=> vector_o == 8'h2F)
		else $error("source 31 did not win");

	no_line24_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		1 |-> vector_o != 8'h28 && !req_q[24])
		else $error("reserved line 24 seen");

	mask_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!en_lo_q[5] && pend[15:6] == 10'h000 && pend[31:16] == 16'h0000 |=> vector_o != 8'h15)
		else $error("disabled source won");

	enable_reset_a: assert property (@(posedge mclk_i)
		$rose(rst_n_i) |-> en_lo_q == 16'hFFFF && en_hi_q == 16'hFFFF)
		else $error("enables not all ones after reset");

	nmi_pass_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		nmi_i && block_q |=> nmi_o)
		else $error("nmi blocked during handler");

	ack_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_ack ##1 s_gie_held |-> !cpu_irq_o)
		else $error("nesting not disabled after ack");

	renest_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_gie_back ##0 win.valid |=> cpu_irq_o)
		else $error("nesting not reopened");

	ack_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_ack |=> !cpu_irq_o)
		else $error("request not dropped after ack");

	vec_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		pend == 32'h00000000 |=> vector_o == `MISP_VEC_BASE)
		else $error("idle vector not base");

endmodule

// ---- misp_cpu_model.sv ----
// Purpose: processor core model taking maskable interrupts
// Assumes: one acknowledge pulse per request, handler reopens nesting
// Notes: counts acks and vectors that hit the default handler
`timescale 1ns/1ps

module misp_cpu_model
#(
	parameter int HOLD = 6
)
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic irq_i,
	input wire logic [7:0] vector_i,
	output logic gie_o,
	output logic inta_o,
	output logic [7:0] vec_o,
	output int acks_o,
	output int spur_o
);
	int cnt;

	// ----------
	// ack cycle
	// ----------
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			gie_o <= 1'b1;
			inta_o <= 1'b0;
			vec_o <= 8'h00;
			cnt <= 0;
			acks_o <= 0;
			spur_o <= 0;
		end
		else if (inta_o)
		begin
			inta_o <= 1'b0;
			gie_o <= 1'b0;
			cnt <= HOLD;
			// the vector byte is fetched while the ack cycle is open
			vec_o <= vector_i;
			if (vector_i == 8'h10)
				spur_o <= spur_o + 1;
		end
		else if (cnt != 0)
		begin
			cnt <= cnt - 1;
			// bench leaves sources asserted across the reopen, so a held request is acked again
			if (cnt == 1)
				gie_o <= 1'b1;
		end
		else if (run_i && gie_o && irq_i)
		begin
			inta_o <= 1'b1;
			acks_o <= acks_o + 1;
		end
	end
endmodule

// ---- test_maskable_irq_status_priority.sv ----
// Purpose: self-checking bench of the maskable irq block
// Assumes: core model answers acks, bench plays the peripherals
// Notes: random stimulus from a fixed seed
`timescale 1ns/1ps
`include "misp_map.svh"

module test_maskable_irq_status_priority
	import misp_pkg::*;
;
	logic mclk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, nmi = 0, run = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, src = 32'h0, rd, en;
	logic err;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, gie, inta, cpu_irq, nmi_o, irq_o;
	wire logic [7:0] vec, cvec;
	int error_cnt = 0, n_checks = 0, seed = 19, acks, spur;

	always #4 mclk_i = ~mclk_i;

	misp_core #(.ADDR_W(8)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_src_i(src),
		.nmi_i(nmi), .gie_i(gie), .inta_i(inta), .cpu_irq_o(cpu_irq), .nmi_o(nmi_o),
		.vector_o(vec), .irq_o(irq_o));
	misp_cpu_model #(.HOLD(6)) CPU (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(run),
		.irq_i(cpu_irq), .vector_i(vec), .gie_o(gie), .inta_o(inta), .vec_o(cvec),
		.acks_o(acks), .spur_o(spur));

	// ----------
	// helpers
	// ----------
	task end_sim;
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wacks(input int n);
		int t;
		t = 0;
		while (acks < n && t < 200)
		begin
			@(posedge mclk_i);
			t++;
		end
		if (t >= 200)
		begin
			error_cnt++;
			end_sim();
		end
	endtask

	function logic [7:0] ad(input logic [5:0] idx);
		ad = {idx, 2'b00};
	endfunction

	// last hit wins, so the top source decides
	function logic [7:0] exp_vec(input logic [31:0] s, input logic [31:0] e);
		logic [31:0] m;
		m = s & e & `MISP_SRC_USED;
		exp_vec = `MISP_VEC_BASE;
		for (int i = 1; i < 32; i++)
			if (m[i])
				exp_vec = `MISP_VEC_BASE + 8'(i);
	endfunction

	// ----------
	// main sequence
	// ----------
	initial
	begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		chk("vector_rst", {24'h0, vec}, 32'h10);
		apb(0, ad(`MISP_IDX_EN_LO), 0); chk("en_lo_rst", rd, 32'hFFFF);
		apb(0, ad(`MISP_IDX_EN_HI), 0); chk("en_hi_rst", rd, 32'hFFFF);
		apb(0, ad(`MISP_IDX_EVT_MASK), 0); chk("mask_rst", rd, 32'h0);
		apb(0, 8'h04, 0); chk("bad_err", {31'h0, err}, 32'h1);
		chk("bad_rd", rd, 32'h0);
		apb(1, ad(`MISP_IDX_STAT_LO), 32'hFFFF);
		for (int k = 0; k < 40; k++)
		begin
			en = (k < 3) ? 32'hFFFFFFFF : $random(seed);
			apb(1, ad(`MISP_IDX_EN_LO), {16'h0, en[15:0]});
			apb(1, ad(`MISP_IDX_EN_HI), {16'h0, en[31:16]});
			src <= (k == 0) ? 32'h01000001 : (k == 1) ? 32'hFFFFFFFF : $random(seed);
			nmi <= 1'($random(seed));
			repeat (3) @(posedge mclk_i);
			#1;
			chk("vector_o", {24'h0, vec}, {24'h0, exp_vec(src, en)});
			chk("nmi_o", {31'h0, nmi_o}, {31'h0, nmi});
			apb(0, ad(`MISP_IDX_STAT_LO), 0);
			chk("stat_lo", rd, {16'h0, src[15:1], 1'b0});
			apb(0, ad(`MISP_IDX_STAT_HI), 0);
			chk("stat_hi", rd, {16'h0, src[31:25], 1'b0, src[23:16]});
			apb(0, ad(`MISP_IDX_VECTOR), 0);
			chk("vector_rd", rd, {24'h0, exp_vec(src, en)});
		end
		apb(1, ad(`MISP_IDX_EN_LO), 32'hFFFF);
		apb(1, ad(`MISP_IDX_EN_HI), 32'hFFFF);
		src <= 32'h80000000;
		nmi <= 1'b1;
		// let the vector settle so the first ack fetches the new winner
		repeat (3) @(posedge mclk_i);
		run <= 1'b1;
		wacks(1);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("irq_blocked", {31'h0, cpu_irq}, 32'h0);
		chk("nmi_nested", {31'h0, nmi_o}, 32'h1);
		chk("ack_vec", {24'h0, cvec}, 32'h2F);
		wacks(2);
		run <= 1'b0;
		src <= 32'h0;
		#1;
		chk("nest_vec", {24'h0, cvec}, 32'h2F);
		chk("spur_none", spur, 32'h0);
		apb(0, ad(`MISP_IDX_EVT), 0); chk("evt_ack", rd, 32'h2);
		chk("irq_masked", {31'h0, irq_o}, 32'h0);
		apb(1, ad(`MISP_IDX_EVT_MASK), 32'h2);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("irq_on", {31'h0, irq_o}, 32'h1);
		apb(1, ad(`MISP_IDX_EVT), 32'h2);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("irq_clr", {31'h0, irq_o}, 32'h0);
		apb(0, ad(`MISP_IDX_EVT), 0); chk("evt_clr", rd, 32'h0);
		// request withdrawn just before the ack: the core fetches the base vector
		src <= 32'h00008000;
		repeat (3) @(posedge mclk_i);
		src <= 32'h0;
		@(posedge mclk_i);
		run <= 1'b1;
		wacks(3);
		run <= 1'b0;
		#1;
		chk("spur_vec", {24'h0, cvec}, 32'h10);
		chk("spur_cnt", spur, 32'h1);
		apb(0, ad(`MISP_IDX_EVT), 0);
		chk("evt_spur", rd, 32'h3);
		end_sim();
	end
endmodule
